// >>> shared/tls_pkg.sv
// Constants for the temperature limit status and hottest-of block.
// Assumes a register read port driven by the serial interface engine.

package tls_pkg;

   // ----------------------------------------
   // Channel and data layout
   // ----------------------------------------
   localparam int NCH  = 8;
   localparam int TW   = 11;
   localparam int FRAC = 3;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_HOT_HI = 8'h32;
   localparam logic [7:0] ADDR_HOT_LO = 8'h33;
   localparam logic [7:0] ADDR_HOT_FL = 8'h34;
   localparam logic [7:0] ADDR_HIGH   = 8'h35;
   localparam logic [7:0] ADDR_LOW    = 8'h36;
   localparam logic [7:0] ADDR_CRIT   = 8'h37;

   // ----------------------------------------
   // Values after reset
   // ----------------------------------------
   localparam logic [7:0] RST_HOT_HI = 8'h80;
   localparam logic [7:0] RST_ZERO   = 8'h00;

   // ----------------------------------------
   // Consecutive count codes, others mean one
   // ----------------------------------------
   localparam logic [2:0] QCODE_2 = 3'h1;
   localparam logic [2:0] QCODE_3 = 3'h3;
   localparam logic [2:0] QCODE_4 = 3'h7;
   localparam logic [1:0] QREACH_1 = 2'h0;
   localparam logic [1:0] QREACH_2 = 2'h1;
   localparam logic [1:0] QREACH_3 = 2'h2;
   localparam logic [1:0] QREACH_4 = 2'h3;

endpackage

// >>> logic/tls_fault_queue.sv
// Per-channel consecutive out-of-limit counters for eight channels.
// Assumes conv_done pulses once per finished conversion cycle.
`timescale 1ns/1ps

module tls_fault_queue (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_n,
   // Measurement results
   input  wire logic       conv_done,
   input  wire logic [7:0] over,
   // Queue setting
   input  wire logic       need_one,
   input  wire logic [2:0] code,
   // Qualified result, valid while conv_done is high
   output      logic [7:0] met
);

   logic [1:0] reach;
   logic [1:0] cnt_reg [8];

   // ----------------------------------------
   // Count decode
   // ----------------------------------------
   // Comparator mode forces a single occurrence for some conditions
   assign reach = need_one           ? tls_pkg::QREACH_1 :
                  code == tls_pkg::QCODE_2 ? tls_pkg::QREACH_2 :
                  code == tls_pkg::QCODE_3 ? tls_pkg::QREACH_3 :
                  code == tls_pkg::QCODE_4 ? tls_pkg::QREACH_4 :
                  tls_pkg::QREACH_1;

   // ----------------------------------------
   // Counters
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_q
         // Saturating count, any good sample empties the queue
         always_ff @(posedge mclk) begin
            if (!rst_n) begin
               cnt_reg[i] <= 2'h0;
            end else if (conv_done) begin
               cnt_reg[i] <= !over[i] ? 2'h0 :
                             (cnt_reg[i] == 2'h3) ? 2'h3 : cnt_reg[i] + 2'h1;
            end
         end
         assign met[i] = over[i] && (cnt_reg[i] >= reach);
      end
   endgenerate

endmodule

// >>> logic/tls_status.sv
// Hottest-of result and per-channel limit status registers.
// Assumes temperatures and limits are stable while conv_done pulses,
// and that rd_stb comes from the serial engine once per register read.
`timescale 1ns/1ps

module tls_status (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Conversion results, channel i at bits i*11 +: 11
   input  wire logic        conv_done,
   input  wire logic [87:0] temp_in,
   // Limits, channel i at bits i*8 +: 8; crit_hyst is one value shared by all channels
   input  wire logic [63:0] high_lim,
   input  wire logic [63:0] low_lim,
   input  wire logic [63:0] crit_lim,
   input  wire logic [7:0]  crit_hyst,
   // Configuration
   input  wire logic [7:0]  hot_cfg,
   input  wire logic [7:0]  chan_mask,
   input  wire logic [2:0]  alert_queue_count,
   input  wire logic        alert_comp_mode,
   input  wire logic        alert_release,
   // Register read port
   input  wire logic        rd_stb,
   input  wire logic [7:0]  rd_addr,
   output      logic [7:0]  rd_data,
   // Summary bits and alert contribution
   output      logic        high_sum,
   output      logic        low_sum,
   output      logic        crit_sum,
   output      logic        alert_req
);

   // ----------------------------------------
   // Hottest channel picker
   // ----------------------------------------
   // Walks down from channel 7 so a tie falls to the lower channel
   function automatic logic [3:0] hot_pick(input logic [87:0] t,
                                           input logic [7:0]  en);
      logic [3:0]        r;
      logic signed [10:0] best;
      r    = 4'h0;
      best = 11'sh0;
      for (int i = 7; i >= 0; i--) begin
         if (en[i] && (!r[3] || $signed(t[i*11 +: 11]) >= best)) begin
            r    = {1'b1, 3'(i)};
            best = $signed(t[i*11 +: 11]);
         end
      end
      return r;
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [7:0] hot_hi_reg;
   logic [7:0] hot_lo_reg;
   logic [7:0] hot_fl_reg;
   logic [7:0] high_reg;
   logic [7:0] low_reg;
   logic [7:0] crit_reg;
   logic [7:0] high_cond_reg;
   logic [7:0] low_cond_reg;
   logic [7:0] rd_data_reg;
   logic       high_sum_reg;
   logic       low_sum_reg;
   logic       crit_sum_reg;
   logic       alert_req_reg;

   logic [7:0] high_next;
   logic [7:0] low_next;
   logic [7:0] crit_next;
   logic [7:0] hi_over;
   logic [7:0] lo_over;
   logic [7:0] cr_over;
   logic [7:0] cr_gone;
   logic [7:0] hi_met;
   logic [7:0] lo_met;
   logic [7:0] cr_met;

   // ----------------------------------------
   // Limit comparisons
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_cmp
         wire signed [11:0] t12;
         wire signed [11:0] hl12;
         wire signed [11:0] ll12;
         wire signed [11:0] cl12;
         wire signed [12:0] rel13;
         // Limits are whole degrees, so align them to the fraction
         assign t12   = {temp_in[i*11+10], temp_in[i*11 +: 11]};
         assign hl12  = {high_lim[i*8+7], high_lim[i*8 +: 8], 3'b000};
         assign ll12  = {low_lim[i*8+7], low_lim[i*8 +: 8], 3'b000};
         assign cl12  = {crit_lim[i*8+7], crit_lim[i*8 +: 8], 3'b000};
         // One extra bit so a critical limit minus a large hysteresis cannot wrap
         assign rel13 = $signed({cl12[11], cl12}) - $signed({2'b00, crit_hyst, 3'b000});
         assign hi_over[i] = t12 >= hl12;
         assign lo_over[i] = t12 < ll12;
         assign cr_over[i] = t12 >= cl12;
         assign cr_gone[i] = $signed({t12[11], t12}) < rel13;
      end
   endgenerate

   // ----------------------------------------
   // Consecutive measurement queues
   // ----------------------------------------
   tls_fault_queue u_q_high (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .conv_done (conv_done),
      .over      (hi_over),
      .need_one  (1'b0),
      .code      (alert_queue_count),
      .met       (hi_met)
   );

   // Low conditions count a single occurrence in comparator mode
   tls_fault_queue u_q_low (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .conv_done (conv_done),
      .over      (lo_over),
      .need_one  (alert_comp_mode),
      .code      (alert_queue_count),
      .met       (lo_met)
   );

   tls_fault_queue u_q_crit (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .conv_done (conv_done),
      .over      (cr_over),
      .need_one  (1'b0),
      .code      (alert_queue_count),
      .met       (cr_met)
   );

   // ----------------------------------------
   // Flag update terms
   // ----------------------------------------
   wire       rd_high = rd_stb && rd_addr == tls_pkg::ADDR_HIGH;
   wire       rd_low  = rd_stb && rd_addr == tls_pkg::ADDR_LOW;
   wire [7:0] hi_set  = conv_done ? hi_met : 8'h00;
   wire [7:0] lo_set  = conv_done ? lo_met : 8'h00;
   wire [7:0] cr_set  = conv_done ? cr_met : 8'h00;

   // Read clears only bits whose last verdict was clean
   wire [7:0] hi_clr =
      alert_comp_mode ? (alert_release ? 8'hff : 8'h00) :
      (rd_high ? ~high_cond_reg : 8'h00);
   wire [7:0] lo_clr = rd_low ? ~low_cond_reg : 8'h00;

   // New events win over a clear in the same cycle
   assign high_next = (high_reg & ~hi_clr) | hi_set;
   assign low_next  = (low_reg & ~lo_clr) | lo_set;
   // Critical bits ignore reads, they release on hysteresis only
   assign crit_next = (crit_reg & ~(conv_done ? cr_gone : 8'h00))
                      | cr_set;

   // Alert sources after per-channel masking
   wire [7:0] hi_alrt = high_next & ~chan_mask;
   wire [7:0] lo_alrt = low_next & ~chan_mask;
   wire       alert_next = (|hi_alrt) ||
                           (!alert_comp_mode && (|lo_alrt));

   // ----------------------------------------
   // Hottest selection
   // ----------------------------------------
   wire [3:0]  pick    = hot_pick(temp_in, hot_cfg);
   wire [10:0] hot_t   = temp_in[pick[2:0]*11 +: 11];
   wire [7:0]  hot_one = 8'h01 << pick[2:0];

   // ----------------------------------------
   // Read data mux
   // ----------------------------------------
   wire [7:0] rd_mux =
      rd_addr == tls_pkg::ADDR_HOT_HI ? hot_hi_reg :
      rd_addr == tls_pkg::ADDR_HOT_LO ? hot_lo_reg :
      rd_addr == tls_pkg::ADDR_HOT_FL ? hot_fl_reg :
      rd_addr == tls_pkg::ADDR_HIGH   ? high_reg :
      rd_addr == tls_pkg::ADDR_LOW    ? low_reg :
      rd_addr == tls_pkg::ADDR_CRIT   ? crit_reg :
      tls_pkg::RST_ZERO;

   // ----------------------------------------
   // Hottest result registers
   // ----------------------------------------
   // Whole result moves together at the end of a conversion cycle
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hot_hi_reg <= tls_pkg::RST_HOT_HI;
         hot_lo_reg <= tls_pkg::RST_ZERO;
         hot_fl_reg <= tls_pkg::RST_ZERO;
      end else if (conv_done && pick[3]) begin
         hot_hi_reg <= hot_t[10:3];
         hot_lo_reg <= {hot_t[2:0], 5'b00000};
         hot_fl_reg <= hot_one;
      end else if (conv_done) begin
         hot_hi_reg <= tls_pkg::RST_HOT_HI;
         hot_lo_reg <= tls_pkg::RST_ZERO;
         hot_fl_reg <= tls_pkg::RST_ZERO;
      end
   end

   // ----------------------------------------
   // Limit flag registers
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         high_reg <= tls_pkg::RST_ZERO;
         low_reg  <= tls_pkg::RST_ZERO;
         crit_reg <= tls_pkg::RST_ZERO;
      end else begin
         high_reg <= high_next;
         low_reg  <= low_next;
         crit_reg <= crit_next;
      end
   end

   // Last qualified verdict per channel, used by the read clear
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         high_cond_reg <= tls_pkg::RST_ZERO;
         low_cond_reg  <= tls_pkg::RST_ZERO;
      end else if (conv_done) begin
         high_cond_reg <= hi_met;
         low_cond_reg  <= lo_met;
      end
   end

   // ----------------------------------------
   // Summary bits, alert and read data
   // ----------------------------------------
   // Summaries track the flags, so a kept flag keeps its summary
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         high_sum_reg  <= 1'b0;
         low_sum_reg   <= 1'b0;
         crit_sum_reg  <= 1'b0;
         alert_req_reg <= 1'b0;
      end else begin
         high_sum_reg  <= |high_next;
         low_sum_reg   <= |low_next;
         crit_sum_reg  <= |crit_next;
         alert_req_reg <= alert_next;
      end
   end

   // Data is sampled before the read clear lands
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rd_data_reg <= tls_pkg::RST_ZERO;
      end else if (rd_stb) begin
         rd_data_reg <= rd_mux;
      end
   end

   assign rd_data   = rd_data_reg;
   assign high_sum  = high_sum_reg;
   assign low_sum   = low_sum_reg;
   assign crit_sum  = crit_sum_reg;
   assign alert_req = alert_req_reg;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_hot_none;
      @(posedge mclk) disable iff (!rst_n)
      conv_done && hot_cfg == 8'h00 |=> hot_hi_reg == 8'h80 && hot_fl_reg == 8'h00;
   endproperty
   a_hot_none: assert property (p_hot_none)
      else $error("hottest high byte not 80h with no channel");

   property p_hot_onehot;
      @(posedge mclk) disable iff (!rst_n)
      conv_done && hot_cfg != 8'h00 |=>
         $onehot(hot_fl_reg) && (hot_fl_reg & $past(hot_cfg)) != 8'h00;
   endproperty
   a_hot_onehot: assert property (p_hot_onehot)
      else $error("hottest flag not one enabled channel");

   property p_hot_frac;
      @(posedge mclk) disable iff (!rst_n)
      hot_lo_reg[4:0] == 5'h00 && $onehot0(hot_fl_reg);
   endproperty
   a_hot_frac: assert property (p_hot_frac)
      else $error("hottest low byte unused bits set");

   property p_high_sum;
      @(posedge mclk) disable iff (!rst_n)
      high_sum_reg == (high_reg != 8'h00);
   endproperty
   a_high_sum: assert property (p_high_sum)
      else $error("high summary disagrees with flags");

   property p_low_rdclr;
      @(posedge mclk) disable iff (!rst_n)
      rd_low && !conv_done |=> (low_reg & ~$past(low_cond_reg)) == 8'h00 ##0 low_sum_reg == (low_reg != 8'h00);
   endproperty
   a_low_rdclr: assert property (p_low_rdclr)
      else $error("low flag with gone condition survived read");

   property p_crit_keep;
      @(posedge mclk) disable iff (!rst_n)
      rd_stb && rd_addr == tls_pkg::ADDR_CRIT && !conv_done |=> crit_reg == $past(crit_reg);
   endproperty
   a_crit_keep: assert property (p_crit_keep)
      else $error("critical flags changed on read");

   property p_comp_hold;
      @(posedge mclk) disable iff (!rst_n)
      alert_comp_mode && rd_high && !alert_release && !conv_done |=> $stable(high_reg);
   endproperty
   a_comp_hold: assert property (p_comp_hold)
      else $error("high flags cleared by read in comparator mode");

   property p_crit_sum;
      @(posedge mclk) disable iff (!rst_n)
      crit_reg != 8'h00 |-> crit_sum_reg;
   endproperty
   a_crit_sum: assert property (p_crit_sum)
      else $error("critical summary clear while flag set");

   property p_low_alert;
      @(posedge mclk) disable iff (!rst_n)
      alert_comp_mode && (high_next & ~chan_mask) == 8'h00 |=> !alert_req_reg;
   endproperty
   a_low_alert: assert property (p_low_alert)
      else $error("alert from low flags in comparator mode");

endmodule

// >>> verif/tls_host.sv
// Register read host that stands in for the serial interface engine.
// Assumes a single clock; reads are issued only through the read task.
`timescale 1ns/1ps

module tls_host (
   // Clock
   input  wire logic       mclk,
   // Register read port
   output      logic       rd_stb,
   output      logic [7:0] rd_addr,
   input  wire logic [7:0] rd_data
);
   // ----------------------------------------
   // Idle levels
   // ----------------------------------------
   initial begin
      rd_stb  = 1'b0;
      rd_addr = 8'h00;
   end

   // Strobe for one edge, data taken one edge later
   // Idle address is inverted so a late latch reads garbage
   task automatic read(input logic [7:0] addr, output logic [7:0] data);
      @(posedge mclk);
      rd_stb  <= 1'b1;
      rd_addr <= addr;
      @(posedge mclk);
      rd_stb  <= 1'b0;
      rd_addr <= ~addr;
      @(posedge mclk);
      data = rd_data;
   endtask
endmodule

// >>> verif/temp_limit_status_hottest_bench.sv
// Self-checking bench for the hottest-of and limit status block.
// Assumes the read host model drives the register read port.
`timescale 1ns/1ps

module temp_limit_status_hottest_bench;
   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   logic        mclk = 1'b0;
   logic        rst_n, conv_done, alert_comp_mode, alert_release, rd_stb;
   logic [87:0] temp_in;
   logic [63:0] high_lim, low_lim, crit_lim;
   logic [7:0]  crit_hyst, hot_cfg, chan_mask, rd_addr, rd_data;
   logic [2:0]  alert_queue_count;
   logic        high_sum, low_sum, crit_sum, alert_req;
   // Expected state
   logic [7:0]  e_high, e_low, e_crit, e_fl, e_hi, e_lo, hc, lc;
   logic        e_none;
   int          seed = 32'h098d;
   int          bad_count = 0;
   int          comparisons = 0;
   int          cycles = 0;

   always #20 mclk = ~mclk;

   tls_status uut (
      .mclk(mclk), .rst_n(rst_n), .conv_done(conv_done), .temp_in(temp_in),
      .high_lim(high_lim), .low_lim(low_lim), .crit_lim(crit_lim),
      .crit_hyst(crit_hyst), .hot_cfg(hot_cfg), .chan_mask(chan_mask),
      .alert_queue_count(alert_queue_count), .alert_comp_mode(alert_comp_mode),
      .alert_release(alert_release), .rd_stb(rd_stb), .rd_addr(rd_addr),
      .rd_data(rd_data), .high_sum(high_sum), .low_sum(low_sum),
      .crit_sum(crit_sum), .alert_req(alert_req)
   );

   tls_host host (.mclk(mclk), .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data));

   // ----------------------------------------
   // Verdict and comparisons
   // ----------------------------------------
   task automatic summarize;
      if (bad_count == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_bit(input string what, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s expected %b seen %b", what, exp, got);
      end
   endtask

   // Hang guard, well above the planned run length
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         summarize;
      end
   end

   // ----------------------------------------
   // Reference model
   // ----------------------------------------
   // Strict greater keeps the lowest channel on a tie
   task automatic model_conv;
      int t;
      int best;
      best = 0;
      e_none = 1'b1;
      e_fl = 8'h00;
      for (int i = 0; i < 8; i++) begin
         t = $signed(temp_in[i*11 +: 11]);
         hc[i] = t >= $signed(high_lim[i*8 +: 8]) * 8;
         lc[i] = t < $signed(low_lim[i*8 +: 8]) * 8;
         if (t >= $signed(crit_lim[i*8 +: 8]) * 8) e_crit[i] = 1'b1;
         else if (t < ($signed(crit_lim[i*8 +: 8]) - int'(crit_hyst)) * 8) e_crit[i] = 1'b0;
         if (hot_cfg[i] && (e_none || t > best)) begin
            e_none = 1'b0;
            best = t;
            e_fl = 8'h01 << i;
         end
      end
      e_high = e_high | hc;
      e_low = e_low | lc;
      e_hi = e_none ? 8'h80 : best[10:3];
      e_lo = {best[2:0], 5'b0_0000};
   endtask

   function automatic logic [7:0] exp_reg(input logic [7:0] a);
      case (a)
         tls_pkg::ADDR_HOT_HI: return e_hi;
         tls_pkg::ADDR_HOT_LO: return e_lo;
         tls_pkg::ADDR_HOT_FL: return e_fl;
         tls_pkg::ADDR_HIGH:   return e_high;
         tls_pkg::ADDR_LOW:    return e_low;
         tls_pkg::ADDR_CRIT:   return e_crit;
         default:              return 8'h00;
      endcase
   endfunction

   // ----------------------------------------
   // Bus and conversion tasks
   // ----------------------------------------
   // Expectation taken before the read-clear lands
   task automatic do_read(input logic [7:0] a);
      logic [7:0] ex;
      logic [7:0] d;
      ex = exp_reg(a);
      host.read(a, d);
      chk_byte("rd_data", ex, d);
      if (a == tls_pkg::ADDR_HIGH && !alert_comp_mode) e_high = e_high & hc;
      if (a == tls_pkg::ADDR_LOW) e_low = e_low & lc;
   endtask

   task automatic convert;
      @(posedge mclk);
      conv_done <= 1'b1;
      @(posedge mclk);
      conv_done <= 1'b0;
      model_conv;
   endtask

   // Settle two edges so registered levels have landed
   task automatic chk_all;
      repeat (2) @(posedge mclk);
      chk_bit("high_sum", |e_high, high_sum);
      chk_bit("low_sum", |e_low, low_sum);
      chk_bit("crit_sum", |e_crit, crit_sum);
      chk_bit("alert_req", |((e_high | (alert_comp_mode ? 8'h00 : e_low)) & ~chan_mask),
              alert_req);
   endtask

   // Full-range critical limits and hysteresis reach release points below -256
   task automatic shuffle;
      @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         temp_in[i*11 +: 11] <= 11'($random(seed));
         high_lim[i*8 +: 8] <= 8'($random(seed));
         low_lim[i*8 +: 8] <= 8'($random(seed));
         crit_lim[i*8 +: 8] <= 8'($random(seed));
      end
      crit_hyst <= 8'($random(seed));
      hot_cfg <= 8'($random(seed));
      chan_mask <= 8'($random(seed));
      alert_comp_mode <= 1'($random(seed));
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [2:0] qc [5];
      int         qn [5];
      logic [7:0] d;
      qc = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h2};
      qn = '{1, 2, 3, 4, 1};
      rst_n = 1'b0; conv_done = 1'b0; alert_release = 1'b0; alert_comp_mode = 1'b0;
      temp_in = '0; high_lim = '0; low_lim = '0; crit_lim = '0; crit_hyst = 8'h00;
      hot_cfg = 8'h00; chan_mask = 8'h00; alert_queue_count = 3'h0;
      e_high = 8'h00; e_low = 8'h00; e_crit = 8'h00; e_fl = 8'h00;
      e_hi = tls_pkg::RST_HOT_HI; e_lo = 8'h00; e_none = 1'b0; hc = 8'h00; lc = 8'h00;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      // Reset values, unmapped neighbours on both sides
      for (int a = 8'h31; a <= 8'h38; a++) do_read(8'(a));
      // Tie over three enabled channels, then nothing enabled
      @(posedge mclk);
      temp_in <= {8{11'h0AD}};
      hot_cfg <= 8'hA4;
      convert;
      for (int a = 8'h32; a <= 8'h34; a++) do_read(8'(a));
      @(posedge mclk);
      hot_cfg <= 8'h00;
      convert;
      for (int a = 8'h32; a <= 8'h34; a++) do_read(8'(a));
      // Random conversions, reads and releases
      for (int n = 0; n < 80; n++) begin
         shuffle;
         convert;
         chk_all;
         repeat (3) do_read(8'h31 + 8'({$random(seed)} % 8));
         if (alert_comp_mode && $random(seed) % 2 == 0) begin
            @(posedge mclk);
            alert_release <= 1'b1;
            @(posedge mclk);
            alert_release <= 1'b0;
            e_high = 8'h00;
         end
         chk_all;
      end
      // Consecutive count codes, each after a fresh reset
      for (int k = 0; k < 5; k++) begin
         @(posedge mclk);
         rst_n <= 1'b0;
         alert_queue_count <= qc[k];
         alert_comp_mode <= 1'b0;
         temp_in <= {11'h000, 11'h000, 11'h320, 11'h000, 11'h000, 11'h000, 11'h000, 11'h000};
         high_lim <= {8{8'h32}};
         low_lim <= {8{8'h80}};
         crit_lim <= {8{8'h7F}};
         repeat (2) @(posedge mclk);
         rst_n <= 1'b1;
         for (int n = 1; n <= qn[k]; n++) begin
            convert;
            host.read(tls_pkg::ADDR_HIGH, d);
            chk_byte("high_limit_flags", (n == qn[k]) ? 8'h20 : 8'h00, d);
         end
      end
      summarize;
   end
endmodule
